/* include/pap_pkg.sv */
// phase active power datapath: shared constants, types and helpers
// assumes a single 25 mhz clock and word-wide register access
package pap_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SAMPLE_PERIOD_NS = 125000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PHASES = 3;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 8;

  // ----------------------------------------------------------------
  // register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COMPUTATION_MODE_REGISTER = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_NOMINAL_VOLTAGE_LEVEL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TGAIN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FGAIN = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_TOFS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_FOFS = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_INST = 8'h20;
  localparam int unsigned CFG_STRENGTH_BIT = 1;
  localparam int unsigned COMPUTATION_MODE_REGISTER_FREQ_BIT = 14;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] COMPUTATION_MODE_REGISTER_RST = 16'h0000;
  localparam logic [DATA_W-1:0] COEF_RST = 24'h000000;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  localparam int unsigned MULT_SHIFT = 19;
  localparam int unsigned INST_SHIFT = 4;
  localparam int unsigned GAIN_FRAC = 23;
  localparam int unsigned LPF_FRAC = 16;
  localparam logic [31:0] FULL_SCALE_POWER = 32'h01ff6a6b;
  localparam int unsigned LPF_SETTLE_SOFT_MS = 650;
  localparam int unsigned LPF_SETTLE_STRONG_MS = 1300;
  localparam int unsigned FUND_SETTLE_63_MS = 375;
  localparam int unsigned FUND_SETTLE_FS_MS = 875;
  localparam logic [3:0] LPF_SHIFT_SOFT = 4'ha;
  localparam logic [3:0] LPF_SHIFT_STRONG = 4'hb;
  localparam logic [3:0] FUND_SHIFT_50 = 4'h9;
  localparam logic [3:0] FUND_SHIFT_60 = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [DATA_W-1:0] volt;
    logic signed [DATA_W-1:0] curr;
  } pap_phase_s;

  typedef struct packed {
    pap_phase_s [PHASES-1:0] ph;
  } pap_frame_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } pap_req_s;

  // 24-bit signed value sign-extended to 28 bits, top nibble zero
  function automatic logic [WORD_W-1:0] pap_word(input logic [DATA_W-1:0] v);
    return {4'h0, {4{v[DATA_W-1]}}, v};
  endfunction

endpackage

/* design/pap_fifo.sv */
// sample fifo between the adc stream and the power datapath
// assumes one clock; the drain side may stall indefinitely
`timescale 1ns/1ps
`default_nettype none
module pap_fifo #(
  parameter int unsigned WIDTH = 144,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      count_q <= count_d;
      in_ready <= (count_d != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* design/pap_lpf.sv */
// first-order low-pass for one power channel, strength set by a shift
// assumes en pulses once per sample period
`timescale 1ns/1ps
`default_nettype none
module pap_lpf
  import pap_pkg::*;
#(
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sample in
  input wire logic en,
  input wire logic signed [W-1:0] x,
  input wire logic [3:0] shift,
  // average out
  output logic signed [W-1:0] y
);
  localparam int unsigned AW = W + LPF_FRAC;

  logic signed [AW-1:0] acc_q;
  logic signed [AW:0] diff;

  always_comb begin
    diff = ($signed({x[W-1], x, {LPF_FRAC{1'b0}}})
            - $signed({acc_q[AW-1], acc_q})) >>> shift;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      y <= '0;
    end else if (en) begin
      acc_q <= acc_q + diff[AW-1:0];
      y <= acc_q[AW-1:LPF_FRAC];
    end
  end
endmodule
`default_nettype wire

/* design/pap_core.sv */
// per-phase active power datapath: product, filter, gain, offset
// assumes samples arrive as frames of three phases, registers by word
// Notes on behaviour
// - Each phase multiplies voltage by current and low-passes it.
// - Strength bit clear selects the faster, 650 ms filter.
// - Strength bit set selects the slower 1300 ms, stronger filter.
// - Instantaneous power is kept per phase as a 24-bit value.
// - Line-frequency bit picks 50 Hz (0) or 60 Hz (1) fundamental.
// - The fundamental result settles within 375 ms to 875 ms.
// - Average power is scaled by one plus gain over 2^23.
// - Gain 0xc00000 halves and 0x400000 raises by half.
// - Total and fundamental paths have their own per-phase gains.
// - Signed per-phase offsets are added in multiplier LSBs.
// - 24-bit values travel as 28-bit sign extension, top nibble 0.
// - A new power value is computed every 125 us.
`timescale 1ns/1ps
`default_nettype none
module pap_core
  import pap_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sample stream
  input wire logic samp_valid,
  input wire pap_frame_s samp_data,
  output logic samp_ready,
  // register port
  input wire pap_req_s reg_req,
  output logic [WORD_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // average power
  output logic [PHASES-1:0][WORD_W-1:0] avg_total,
  output logic [PHASES-1:0][WORD_W-1:0] avg_fund,
  output logic avg_valid
);
  // ----------------------------------------------------------------
  // sample fifo and period tick
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic fifo_valid;
  pap_frame_s fifo_data;
  pap_frame_s frame_q;
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic s4_q;

  pap_fifo #(
    .WIDTH($bits(pap_frame_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(samp_valid),
    .in_data(samp_data),
    .in_ready(samp_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(tick_q)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
      tick_q <= (tick_cnt_q == TICK_LAST);
    end
  end

  // empty fifo at a tick reuses the last frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_q <= '0;
    end else if (tick_q && fifo_valid) begin
      frame_q <= fifo_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      s4_q <= 1'b0;
    end else begin
      s1_q <= tick_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
      s4_q <= s3_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_q;
  logic [15:0] computation_mode_register_q;
  logic [DATA_W-1:0] nominal_voltage_level_q;
  logic [DATA_W-1:0] tgain_q [PHASES];
  logic [DATA_W-1:0] fgain_q [PHASES];
  logic [DATA_W-1:0] tofs_q [PHASES];
  logic [DATA_W-1:0] fofs_q [PHASES];
  logic [DATA_W-1:0] inst_q [PHASES];
  logic [3:0] tshift;
  logic [3:0] fshift;
  logic fund_run;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RST;
      computation_mode_register_q <= COMPUTATION_MODE_REGISTER_RST;
      nominal_voltage_level_q <= COEF_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ADDR_CFG) begin
        cfg_q <= reg_req.wdata[15:0];
      end
      if (reg_req.addr == ADDR_COMPUTATION_MODE_REGISTER) begin
        computation_mode_register_q <= reg_req.wdata[15:0];
      end
      if (reg_req.addr == ADDR_NOMINAL_VOLTAGE_LEVEL) begin
        nominal_voltage_level_q <= reg_req.wdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= '0;
        case (reg_req.addr)
          ADDR_CFG: reg_rdata <= {16'h0000, cfg_q};
          ADDR_COMPUTATION_MODE_REGISTER: reg_rdata <= {16'h0000, computation_mode_register_q};
          ADDR_NOMINAL_VOLTAGE_LEVEL: reg_rdata <= pap_word(nominal_voltage_level_q);
          default: begin
            for (int p = 0; p < PHASES; p++) begin
              if (reg_req.addr == ADDR_TGAIN + 8'(p)) begin
                reg_rdata <= pap_word(tgain_q[p]);
              end
              if (reg_req.addr == ADDR_FGAIN + 8'(p)) begin
                reg_rdata <= pap_word(fgain_q[p]);
              end
              if (reg_req.addr == ADDR_TOFS + 8'(p)) begin
                reg_rdata <= pap_word(tofs_q[p]);
              end
              if (reg_req.addr == ADDR_FOFS + 8'(p)) begin
                reg_rdata <= pap_word(fofs_q[p]);
              end
              if (reg_req.addr == ADDR_INST + 8'(p)) begin
                reg_rdata <= pap_word(inst_q[p]);
              end
            end
          end
        endcase
      end
    end
  end

  // filter strength and line frequency selection
  always_comb begin
    tshift = cfg_q[CFG_STRENGTH_BIT] ? LPF_SHIFT_STRONG
                                     : LPF_SHIFT_SOFT;
    fshift = computation_mode_register_q[COMPUTATION_MODE_REGISTER_FREQ_BIT] ? FUND_SHIFT_60
                                           : FUND_SHIFT_50;
    // fundamental path holds at zero until a positive level is loaded
    fund_run = !nominal_voltage_level_q[DATA_W-1] && (nominal_voltage_level_q != '0);
  end

  // ----------------------------------------------------------------
  // per-phase datapath
  // ----------------------------------------------------------------
  logic signed [2*DATA_W-1:0] prod_q [PHASES];
  logic signed [WORD_W-1:0] mult_q [PHASES];
  logic signed [WORD_W-1:0] ty [PHASES];
  logic signed [WORD_W-1:0] fy [PHASES];
  localparam int unsigned SCL_W = WORD_W + DATA_W;

  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    logic signed [WORD_W+DATA_W-1:0] tscl;
    logic signed [WORD_W+DATA_W-1:0] fscl;
    logic signed [2*DATA_W-1:0] msh;

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        tgain_q[p] <= COEF_RST;
        fgain_q[p] <= COEF_RST;
        tofs_q[p] <= COEF_RST;
        fofs_q[p] <= COEF_RST;
      end else if (reg_req.wr) begin
        if (reg_req.addr == ADDR_TGAIN + 8'(p)) begin
          tgain_q[p] <= reg_req.wdata[DATA_W-1:0];
        end
        if (reg_req.addr == ADDR_FGAIN + 8'(p)) begin
          fgain_q[p] <= reg_req.wdata[DATA_W-1:0];
        end
        if (reg_req.addr == ADDR_TOFS + 8'(p)) begin
          tofs_q[p] <= reg_req.wdata[DATA_W-1:0];
        end
        if (reg_req.addr == ADDR_FOFS + 8'(p)) begin
          fofs_q[p] <= reg_req.wdata[DATA_W-1:0];
        end
      end
    end

    always_comb begin
      msh = prod_q[p] >>> MULT_SHIFT;
      tscl = (SCL_W'(ty[p]) * SCL_W'($signed(tgain_q[p])))
             >>> GAIN_FRAC;
      fscl = (SCL_W'(fy[p]) * SCL_W'($signed(fgain_q[p])))
             >>> GAIN_FRAC;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        prod_q[p] <= '0;
        mult_q[p] <= '0;
        inst_q[p] <= '0;
      end else begin
        if (s1_q) begin
          prod_q[p] <= frame_q.ph[p].volt * frame_q.ph[p].curr;
        end
        if (s2_q) begin
          mult_q[p] <= msh[WORD_W-1:0];
          inst_q[p] <= msh[DATA_W+INST_SHIFT-1:INST_SHIFT];
        end
      end
    end

    pap_lpf #(.W(WORD_W)) u_tlpf (
      .ref_clk(ref_clk),
      .rst(rst),
      .en(s3_q),
      .x(mult_q[p]),
      .shift(tshift),
      .y(ty[p])
    );

    pap_lpf #(.W(WORD_W)) u_flpf (
      .ref_clk(ref_clk),
      .rst(rst),
      .en(s3_q),
      .x(fund_run ? mult_q[p] : '0),
      .shift(fshift),
      .y(fy[p])
    );

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        avg_total[p] <= '0;
        avg_fund[p] <= '0;
      end else if (s4_q) begin
        avg_total[p] <= ty[p] + tscl[WORD_W-1:0]
                        + WORD_W'($signed(tofs_q[p]));
        avg_fund[p] <= fy[p] + fscl[WORD_W-1:0]
                       + WORD_W'($signed(fofs_q[p]));
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= s4_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] since_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // starts one short so the first period after reset counts in full
      since_q <= '1;
    end else begin
      since_q <= tick_q ? '0 : since_q + 1'b1;
    end
  end

  property p_period;
    @(posedge ref_clk) disable iff (rst)
    tick_q && $past(since_q) != '0 |-> $past(since_q) == TICK_LAST - 1'b1;
  endproperty
  a_period: assert property (p_period) else $error("bad sample period");

  property p_product;
    @(posedge ref_clk) disable iff (rst)
    s1_q |=> prod_q[0] == $past(frame_q.ph[0].volt) * $past(frame_q.ph[0].curr);
  endproperty
  a_product: assert property (p_product) else $error("bad product");

  property p_inst;
    @(posedge ref_clk) disable iff (rst)
    s2_q |=> inst_q[1] == 24'($past(prod_q[1]) >>> (MULT_SHIFT + INST_SHIFT));
  endproperty
  a_inst: assert property (p_inst) else $error("bad inst power");

  property p_strength;
    @(posedge ref_clk) disable iff (rst)
    s3_q |-> tshift == (cfg_q[1] ? 4'hb : 4'ha);
  endproperty
  a_strength: assert property (p_strength) else $error("bad strength");

  property p_freq;
    @(posedge ref_clk) disable iff (rst)
    s3_q |-> fshift == (computation_mode_register_q[14] ? 4'h8 : 4'h9);
  endproperty
  a_freq: assert property (p_freq) else $error("bad freq select");

  property p_half;
    @(posedge ref_clk) disable iff (rst)
    s4_q && tgain_q[0] == 24'hc00000 && tofs_q[0] == '0
    |=> $signed(avg_total[0]) == ($past(ty[0]) >>> 1);
  endproperty
  a_half: assert property (p_half) else $error("bad half gain");

  property p_offset;
    @(posedge ref_clk) disable iff (rst)
    s4_q && fgain_q[2] == '0
    |=> $signed(avg_fund[2]) == $past(fy[2]) + $signed($past(fofs_q[2]));
  endproperty
  a_offset: assert property (p_offset) else $error("bad offset");

  property p_word;
    @(posedge ref_clk) disable iff (rst)
    reg_req.rd && reg_req.addr == ADDR_TGAIN
    |=> reg_rvalid
        && reg_rdata == {4'h0, {4{$past(tgain_q[0][23])}}, $past(tgain_q[0])};
  endproperty
  a_word: assert property (p_word) else $error("bad word format");

  property p_separate;
    @(posedge ref_clk) disable iff (rst)
    reg_req.wr && reg_req.addr == ADDR_TGAIN |=> $stable(fgain_q[0]);
  endproperty
  a_separate: assert property (p_separate) else $error("gain crosstalk");

  property p_boot;
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> tgain_q[1] == '0 && fofs_q[1] == '0;
  endproperty
  a_boot: assert property (p_boot) else $error("coef not zero");

  property p_out_tick;
    @(posedge ref_clk) disable iff (rst)
    tick_q |-> ##5 avg_valid;
  endproperty
  a_out_tick: assert property (p_out_tick) else $error("late output");

  c_full: cover property (@(posedge ref_clk) disable iff (rst) !samp_ready);
  c_strong: cover property (@(posedge ref_clk) disable iff (rst)
    avg_valid && cfg_q[1]);
  c_fund: cover property (@(posedge ref_clk) disable iff (rst)
    avg_valid && fund_run && computation_mode_register_q[14]);
endmodule
`default_nettype wire

/* tb/pap_adc_model.sv */
// adc sample source for the power datapath: one frame of three phases
// assumes the bench drives run, volt and curr just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pap_adc_model
  import pap_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control from the bench
  input wire logic run,
  input wire logic [DATA_W-1:0] volt,
  input wire logic [DATA_W-1:0] curr,
  // stream towards the block
  output logic samp_valid,
  output pap_frame_s samp_data,
  input wire logic samp_ready
);
  // ----------------------------------------------------------------
  // frame offer: held until the block takes it
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      samp_valid <= 1'b0;
      samp_data <= '0;
    end else if (!samp_valid || samp_ready) begin
      samp_valid <= run;
      if (run) begin
        for (int p = 0; p < PHASES; p++) begin
          samp_data.ph[p].volt <= volt;
          samp_data.ph[p].curr <= curr;
        end
      end else begin
        // an idle bus toggles between the last frame and its inverse
        samp_data <= ~samp_data;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/phase_active_power_datapath_bench.sv */
// self-checking bench for the phase active power datapath
// assumes pap_core with a shallow fifo and the adc model beside it
`timescale 1ns/1ps
`default_nettype none
module phase_active_power_datapath_bench;
  import pap_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk, rst, run, samp_valid, samp_ready, reg_rvalid, avg_valid;
  logic [DATA_W-1:0] volt, curr;
  pap_frame_s samp_data;
  pap_req_s reg_req;
  logic [WORD_W-1:0] reg_rdata;
  logic [PHASES-1:0][WORD_W-1:0] avg_total, avg_fund;
  logic signed [WORD_W-1:0] y, f, t_soft, f_50;
  int n_fail, cmp_count, gap;

  pap_core #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .rst(rst),
    .samp_valid(samp_valid), .samp_data(samp_data),
    .samp_ready(samp_ready), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .avg_total(avg_total), .avg_fund(avg_fund),
    .avg_valid(avg_valid));
  pap_adc_model adc (.ref_clk(ref_clk), .rst(rst), .run(run),
    .volt(volt), .curr(curr), .samp_valid(samp_valid),
    .samp_data(samp_data), .samp_ready(samp_ready));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // checks and verdict
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [WORD_W-1:0] exp,
                          input logic [WORD_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_true(input string what, input logic cond);
    cmp_count++;
    if (cond !== 1'b1) begin
      n_fail++;
      $display("unexpected %s: expected 1, seen %b", what, cond);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // register port and stream helpers
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [WORD_W-1:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  task automatic chk_read(input string what, input logic [ADDR_W-1:0] a,
                          input logic [WORD_W-1:0] exp);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    chk_true("read valid", reg_rvalid);
    chk_word(what, exp, reg_rdata);
  endtask

  // waits for the next result pulse and returns the cycles it took
  task automatic wait_avg(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (avg_valid !== 1'b1 && n < 4000);
    chk_true("avg_valid", avg_valid);
  endtask

  // reset, check reset values, then configure and start the samples
  task automatic start_run(input logic [15:0] cfg, input logic [15:0] cm,
                           input logic [WORD_W-1:0] lvl);
    run <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 32; a++) begin
      chk_read("reset value", 8'(a), 32'h0);
    end
    reg_write(ADDR_CFG, {16'h0, cfg});
    reg_write(ADDR_COMPUTATION_MODE_REGISTER, {16'h0, cm});
    // a level that is not positive keeps the fundamental path at zero
    reg_write(ADDR_NOMINAL_VOLTAGE_LEVEL, lvl);
    run <= 1'b1;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    $display("unexpected run length: expected end, seen hang");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    run = 1'b0;
    volt = 24'h400000;
    curr = 24'h400000;
    reg_req = '0;
    n_fail = 0;
    cmp_count = 0;
    // soft filter, 50 hz, gains on chosen phases only
    start_run(16'h0000, 16'h0000, 32'h00078000);
    reg_write(ADDR_TGAIN, 32'h00c00000);
    reg_write(ADDR_TGAIN + 8'h2, 32'h00400000);
    reg_write(ADDR_FGAIN + 8'h1, 32'h00400000);
    reg_write(ADDR_INST, 32'h00123456);
    chk_read("total gain a", ADDR_TGAIN, 32'h0fc00000);
    chk_read("total gain c", ADDR_TGAIN + 8'h2, 32'h00400000);
    chk_read("fund gain a", ADDR_FGAIN, 32'h0);
    repeat (3) wait_avg(gap);
    wait_avg(gap);
    chk_word("sample period", 32'(gap), 32'(SAMPLE_CYCLES));
    for (int p = 0; p < 3; p++) begin
      chk_read("inst power", ADDR_INST + 8'(p), 32'h00200000);
    end
    y = avg_total[1];
    f = avg_fund[0];
    t_soft = y;
    f_50 = f;
    chk_true("total average positive", y > 0);
    chk_word("total gain half", y + ((-y) >>> 1), avg_total[0]);
    chk_word("total gain plus", y + (y >>> 1), avg_total[2]);
    chk_word("fund gain kept", f, avg_fund[2]);
    chk_word("fund gain plus", f + (f >>> 1), avg_fund[1]);
    // strong filter, offsets on total c and fund a, negative level
    start_run(16'h0002, 16'h0000, 32'h00f80000);
    reg_write(ADDR_TOFS + 8'h2, 32'h00fffff0);
    reg_write(ADDR_FOFS, 32'h00000005);
    chk_read("total offset c", ADDR_TOFS + 8'h2, 32'h0ffffff0);
    chk_read("level word", ADDR_NOMINAL_VOLTAGE_LEVEL, 32'h0ff80000);
    repeat (4) wait_avg(gap);
    y = avg_total[1];
    chk_true("strong filter slower", y < t_soft);
    chk_word("total offset", y - 32'h10, avg_total[2]);
    chk_word("fund offset", avg_fund[1] + 32'h5, avg_fund[0]);
    chk_word("fund held", 32'h0, avg_fund[1]);
    // 60 hz fundamental, total path untouched
    start_run(16'h0000, 16'h4000, 32'h00078000);
    repeat (4) wait_avg(gap);
    f = avg_fund[0];
    chk_true("fund 60 hz faster", f > f_50);
    chk_word("total path same", t_soft, avg_total[1]);
    // the source never stops, so the fifo is full; then drain it
    chk_true("fifo refuses", samp_ready === 1'b0);
    run <= 1'b0;
    repeat (9) wait_avg(gap);
    chk_true("fifo drained", samp_ready === 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
